// ==== shared/ubal_consts.svh ====
// Named constants for the baud, loopback and address-watch serial block.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef UBAL_CONSTS_SVH
`define UBAL_CONSTS_SVH
`define UBAL_OFF_CTRL    8'h00
`define UBAL_OFF_RXCS    8'h04
`define UBAL_OFF_TXBUF   8'h08
`define UBAL_OFF_RXBUF   8'h0c
`define UBAL_OFF_BAUD    8'h10
`define UBAL_OFF_PSR     8'h14
`define UBAL_OFF_MODE    8'h18
`define UBAL_CTRL_CL_LO  0
`define UBAL_CTRL_CL_HI  1
`define UBAL_CTRL_TX9    2
`define UBAL_CTRL_STOP2  3
`define UBAL_CTRL_STOP78 4
`define UBAL_CTRL_TX_BUFFER_EMPTY_FLAG   5
`define UBAL_CTRL_XMTG   6
`define UBAL_RXCS_ADDRESS_WATCH_ENABLE   0
`define UBAL_RXCS_RX9    1
`define UBAL_RXCS_FERR   2
`define UBAL_RXCS_OERR   3
`define UBAL_RXCS_RX_BUFFER_FULL_FLAG   4
`define UBAL_MODE_SYNC   0
`define UBAL_MODE_ERI    1
`define UBAL_RST_BYTE    8'h00
`define UBAL_OS_ASYNC    4'hf
`define UBAL_OS_SYNC     4'h1
`define UBAL_OS_STOP78   4'hd
`define UBAL_CLK_NS      10
`define UBAL_TC_NS       10
`define UBAL_WAKE_TC     256
`define UBAL_WAKE_CYC    ((`UBAL_WAKE_TC * `UBAL_TC_NS) / `UBAL_CLK_NS)
`endif

// ==== shared/ubal_pkg.sv ====
// Types shared by the serial block and its baud generator helper.
// Assumes nothing beyond a SystemVerilog compiler.
package ubal_pkg;
	// Baud generator settings: prescaler select and eleven-bit divisor.
	typedef struct packed {
		logic [4:0]  psel;
		logic [10:0] divisor;
	} ubal_baud_t;

	// Transmitter states.
	typedef enum logic [1:0] {
		UBAL_TX_IDLE  = 2'b01,
		UBAL_TX_SHIFT = 2'b10
	} ubal_tx_state_t;

	// Receiver states.
	typedef enum logic [3:0] {
		UBAL_RX_IDLE  = 4'b0001,
		UBAL_RX_START = 4'b0010,
		UBAL_RX_DATA  = 4'b0100,
		UBAL_RX_STOP  = 4'b1000
	} ubal_rx_state_t;
endpackage : ubal_pkg

// ==== src/ubal_baud_gen.sv ====
// Two-stage baud generator: half-step prescaler, then divisor counter.
// Assumes settings are changed only while the prescaler select is zero.
`timescale 1ns/1ps
`include "ubal_consts.svh"
module ubal_baud_gen (
	input  wire logic               clk,
	input  wire logic               rst_n,
	input  wire ubal_pkg::ubal_baud_t cfg,
	output logic                    os_tick
);
	logic [5:0]  acc_reg;
	logic [5:0]  acc_sum;
	logic [5:0]  period;
	logic        pre_tick_reg;
	logic [10:0] div_reg;

	////////////////////////////////////////////////////////////////////////
	// Prescaler counts half cycles so even codes alternate short and long.
	assign acc_sum = acc_reg + 6'h02;
	assign period  = {1'b0, cfg.psel} + 6'h01;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_reg      <= 6'h00;
			pre_tick_reg <= 1'b0;
		end else if (cfg.psel == 5'h00) begin
			acc_reg      <= 6'h00;
			pre_tick_reg <= 1'b0;
		end else if (acc_sum >= period) begin
			acc_reg      <= acc_sum - period;
			pre_tick_reg <= 1'b1;
		end else begin
			acc_reg      <= acc_sum;
			pre_tick_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Divisor counter reloads the programmed value, so it divides by N+1.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_reg <= 11'h000;
			os_tick <= 1'b0;
		end else if (cfg.psel == 5'h00) begin
			div_reg <= 11'h000;
			os_tick <= 1'b0;
		end else if (pre_tick_reg && div_reg == 11'h000) begin
			div_reg <= cfg.divisor;
			os_tick <= 1'b1;
		end else begin
			div_reg <= pre_tick_reg ? div_reg - 11'h001 : div_reg;
			os_tick <= 1'b0;
		end
	end

	property p_stopped;
		@(posedge clk) disable iff (!rst_n)
		cfg.psel == 5'h00 |=> !os_tick;
	endproperty
	a_stopped: assert property (p_stopped)
		else $error("baud tick while prescaler stopped");

	property p_unity;
		@(posedge clk) disable iff (!rst_n)
		cfg.psel == 5'h00 ##1 (cfg.psel == 5'h01 && cfg.divisor == 11'h000)[*3]
		|-> os_tick;
	endproperty
	a_unity: assert property (p_unity)
		else $error("unity divide gives no tick");

	property p_div3;
		@(posedge clk) disable iff (!rst_n)
		(cfg.psel == 5'h01 && cfg.divisor == 11'h002) ##1
		(cfg.psel == 5'h01 && cfg.divisor == 11'h002 && os_tick) ##1
		(cfg.psel == 5'h01 && cfg.divisor == 11'h002)[*3]
		|-> os_tick && !$past(os_tick) && !$past(os_tick, 2);
	endproperty
	a_div3: assert property (p_div3)
		else $error("divisor two does not divide by three");
endmodule : ubal_baud_gen

// ==== src/ubal_wake.sv ====
// Low-power wake on a receive start bit, and the crystal start-up hold.
// Assumes the receive pin is synchronous to the clock.
`timescale 1ns/1ps
`include "ubal_consts.svh"
module ubal_wake (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic lp_enter,
	input  wire logic rx_pin,
	input  wire logic wake_en3,
	input  wire logic wake_edge3,
	input  wire logic xtal_halt,
	output logic      wakeup,
	output logic      exec_hold
);
	logic       lp_reg;
	logic       rx_prev_reg;
	logic       wake_hit;
	logic [8:0] hold_cnt_reg;
	logic [9:0] hold_len_reg;

	////////////////////////////////////////////////////////////////////////
	// A falling edge while asleep and enabled is the start bit that wakes.
	assign wake_hit = lp_reg && wake_en3 && wake_edge3 &&
		rx_prev_reg && !rx_pin;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lp_reg      <= 1'b0;
			rx_prev_reg <= 1'b1;
			wakeup      <= 1'b0;
		end else begin
			lp_reg      <= lp_enter | (lp_reg & ~wake_hit);
			rx_prev_reg <= rx_pin;
			wakeup      <= wake_hit;
		end
	end

	// Execution is held while the crystal settles after a halt wake.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			exec_hold    <= 1'b0;
			hold_cnt_reg <= 9'h000;
		end else if (wake_hit && xtal_halt) begin
			exec_hold    <= 1'b1;
			hold_cnt_reg <= 9'(`UBAL_WAKE_CYC - 1);
		end else if (exec_hold) begin
			exec_hold    <= hold_cnt_reg != 9'h000;
			hold_cnt_reg <= hold_cnt_reg - 9'h001;
		end
	end

	// Helper for the hold-length check only.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) hold_len_reg <= 10'h000;
		else hold_len_reg <= exec_hold ? hold_len_reg + 10'h001 : 10'h000;
	end

	property p_hold_len;
		@(posedge clk) disable iff (!rst_n)
		$fell(exec_hold) |-> hold_len_reg == 10'h100;
	endproperty
	a_hold_len: assert property (p_hold_len)
		else $error("start-up hold not 256 cycles");

	property p_wake;
		@(posedge clk) disable iff (!rst_n)
		lp_reg && wake_en3 && wake_edge3 && $fell(rx_pin) |-> ##1 wakeup;
	endproperty
	a_wake: assert property (p_wake)
		else $error("start bit did not wake");
endmodule : ubal_wake

// ==== src/ubal_top.sv ====
// Serial block top: APB registers, transmitter, receiver, loopback,
// address watch and low-power reinitialisation.
// Assumes an APB master, pins synchronous to MCLK, one clock domain.
`timescale 1ns/1ps
`include "ubal_consts.svh"
module ubal_top (
	input  wire logic        MCLK,
	input  wire logic        RESET_N,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic        SERIAL_RX_PIN,
	output logic             SERIAL_TX_PIN,
	input  wire logic        LP_ENTER,
	input  wire logic        XTAL_HALT,
	input  wire logic        WAKE_EN3,
	input  wire logic        WAKE_EDGE3,
	output logic             WAKEUP,
	output logic             EXEC_HOLD,
	output logic             RX_IRQ
);
	// Control and status state.
	logic [1:0]  cl_reg;
	logic        tx9_reg;
	logic        stop2_reg;
	logic        stop78_reg;
	logic        tx_buffer_empty_flag_reg;
	logic        address_watch_enable_reg;
	logic        rx9_reg;
	logic        ferr_reg;
	logic        oerr_reg;
	logic        rx_buffer_full_flag_reg;
	logic        sync_reg;
	logic        eri_reg;
	logic [7:0]  txbuf_reg;
	logic [7:0]  rxbuf_reg;
	logic [7:0]  baud_lo_reg;
	logic [7:0]  psr_reg;
	logic [31:0] rd_word;
	// Bus strobes.
	logic        acc_wr;
	logic        acc_rd;
	logic        wr_ctrl;
	logic        wr_rxcs;
	logic        wr_txbuf;
	logic        rd_rxbuf;
	// Datapath.
	logic                   os_tick;
	logic                   loop;
	logic [3:0]             nbits;
	logic [3:0]             os_lim;
	logic [3:0]             tx_lim;
	ubal_pkg::ubal_baud_t   baud_cfg;
	ubal_pkg::ubal_tx_state_t tx_state_reg;
	logic [11:0]            tx_shift_reg;
	logic [3:0]             tx_left_reg;
	logic [3:0]             tx_phase_reg;
	logic                   tx_load;
	logic [8:0]             tx_field;
	ubal_pkg::ubal_rx_state_t rx_state_reg;
	logic [3:0]             rx_phase_reg;
	logic [3:0]             rx_cnt_reg;
	logic [8:0]             rx_shift_reg;
	logic                   rx_in;
	logic                   rx_done;
	logic                   rx_accept;
	logic [7:0]             rx_data;
	logic                   rx_nin;

	////////////////////////////////////////////////////////////////////////
	// Data bits per character; both length bits set means nine.
	function automatic logic [3:0] char_bits(input logic [1:0] cl);
		case (cl)
			2'b01:   char_bits = 4'h7;
			2'b00:   char_bits = 4'h8;
			default: char_bits = 4'h9;
		endcase
	endfunction : char_bits

	// True for every offset that answers without error.
	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a == `UBAL_OFF_CTRL) || (a == `UBAL_OFF_RXCS) ||
			(a == `UBAL_OFF_TXBUF) || (a == `UBAL_OFF_RXBUF) ||
			(a == `UBAL_OFF_BAUD) || (a == `UBAL_OFF_PSR) ||
			(a == `UBAL_OFF_MODE);
	endfunction : is_mapped

	////////////////////////////////////////////////////////////////////////
	// APB slave with no wait states; unmapped offsets answer with an error.
	assign PREADY   = 1'b1;
	assign acc_wr   = PSEL && PENABLE && PWRITE;
	assign acc_rd   = PSEL && PENABLE && !PWRITE;
	assign PSLVERR  = PSEL && PENABLE && !is_mapped(PADDR);
	assign wr_ctrl  = acc_wr && PADDR == `UBAL_OFF_CTRL;
	assign wr_rxcs  = acc_wr && PADDR == `UBAL_OFF_RXCS;
	assign wr_txbuf = acc_wr && PADDR == `UBAL_OFF_TXBUF;
	assign rd_rxbuf = acc_rd && PADDR == `UBAL_OFF_RXBUF;

	// Read multiplexer; unused upper bits read as zero.
	always_comb begin
		rd_word = 32'h0000_0000;
		case (PADDR)
			`UBAL_OFF_CTRL: begin
				rd_word[`UBAL_CTRL_CL_HI:`UBAL_CTRL_CL_LO] = cl_reg;
				rd_word[`UBAL_CTRL_TX9]    = tx9_reg;
				rd_word[`UBAL_CTRL_STOP2]  = stop2_reg;
				rd_word[`UBAL_CTRL_STOP78] = stop78_reg;
				rd_word[`UBAL_CTRL_TX_BUFFER_EMPTY_FLAG]   = tx_buffer_empty_flag_reg;
				rd_word[`UBAL_CTRL_XMTG]   =
					tx_state_reg == ubal_pkg::UBAL_TX_SHIFT;
			end
			`UBAL_OFF_RXCS: begin
				rd_word[`UBAL_RXCS_ADDRESS_WATCH_ENABLE] = address_watch_enable_reg;
				rd_word[`UBAL_RXCS_RX9]  = rx9_reg;
				rd_word[`UBAL_RXCS_FERR] = ferr_reg;
				rd_word[`UBAL_RXCS_OERR] = oerr_reg;
				rd_word[`UBAL_RXCS_RX_BUFFER_FULL_FLAG] = rx_buffer_full_flag_reg;
			end
			`UBAL_OFF_TXBUF: rd_word[7:0] = txbuf_reg;
			`UBAL_OFF_RXBUF: rd_word[7:0] = rxbuf_reg;
			`UBAL_OFF_BAUD:  rd_word[7:0] = baud_lo_reg;
			`UBAL_OFF_PSR:   rd_word[7:0] = psr_reg;
			`UBAL_OFF_MODE: begin
				rd_word[`UBAL_MODE_SYNC] = sync_reg;
				rd_word[`UBAL_MODE_ERI]  = eri_reg;
			end
			default: rd_word = 32'h0000_0000;
		endcase
	end

	// Read data is captured in the setup cycle so it comes from a flop.
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) PRDATA <= 32'h0000_0000;
		else if (PSEL && !PENABLE) PRDATA <= rd_word;
	end

	////////////////////////////////////////////////////////////////////////
	// Plain read/write configuration; low-power entry leaves these alone.
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			cl_reg      <= 2'b00;
			tx9_reg     <= 1'b0;
			stop2_reg   <= 1'b0;
			stop78_reg  <= 1'b0;
			baud_lo_reg <= `UBAL_RST_BYTE;
			psr_reg     <= `UBAL_RST_BYTE;
			sync_reg    <= 1'b0;
			eri_reg     <= 1'b0;
			txbuf_reg   <= `UBAL_RST_BYTE;
		end else begin
			if (wr_ctrl) begin
				cl_reg     <= PWDATA[`UBAL_CTRL_CL_HI:`UBAL_CTRL_CL_LO];
				tx9_reg    <= PWDATA[`UBAL_CTRL_TX9];
				stop2_reg  <= PWDATA[`UBAL_CTRL_STOP2];
				stop78_reg <= PWDATA[`UBAL_CTRL_STOP78];
			end
			if (acc_wr && PADDR == `UBAL_OFF_BAUD)
				baud_lo_reg <= PWDATA[7:0];
			if (acc_wr && PADDR == `UBAL_OFF_PSR)
				psr_reg <= PWDATA[7:0];
			if (acc_wr && PADDR == `UBAL_OFF_MODE) begin
				sync_reg <= PWDATA[`UBAL_MODE_SYNC];
				eri_reg  <= PWDATA[`UBAL_MODE_ERI];
			end
			if (wr_txbuf)
				txbuf_reg <= PWDATA[7:0];
		end
	end

	// The divisor's top three bits sit in the low bits of the select byte.
	assign baud_cfg = '{psel: psr_reg[7:3],
		divisor: {psr_reg[2:0], baud_lo_reg}};

	ubal_baud_gen u_baud (
		.clk     (MCLK),
		.rst_n   (RESET_N),
		.cfg     (baud_cfg),
		.os_tick (os_tick)
	);

	// Sixteen oversample ticks per bit asynchronous, two synchronous.
	assign os_lim = sync_reg ? `UBAL_OS_SYNC : `UBAL_OS_ASYNC;
	assign nbits  = char_bits(cl_reg);
	assign loop   = cl_reg == 2'b11;

	////////////////////////////////////////////////////////////////////////
	// Transmitter. A buffer write stalls the load one cycle so the new
	// byte is never marked empty before it has been loaded.
	assign tx_load = tx_state_reg == ubal_pkg::UBAL_TX_IDLE &&
		!tx_buffer_empty_flag_reg && !wr_txbuf;
	always_comb begin
		case (nbits)
			4'h9:    tx_field = {tx9_reg, txbuf_reg};
			4'h8:    tx_field = {1'b1, txbuf_reg};
			default: tx_field = {2'b11, txbuf_reg[6:0]};
		endcase
	end
	// The last stop bit may be shortened to fourteen of sixteen ticks.
	assign tx_lim = (stop78_reg && !sync_reg && tx_left_reg == 4'h1) ?
		`UBAL_OS_STOP78 : os_lim;

	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			tx_state_reg <= ubal_pkg::UBAL_TX_IDLE;
			tx_shift_reg <= 12'hfff;
			tx_left_reg  <= 4'h0;
			tx_phase_reg <= 4'h0;
		end else if (LP_ENTER) begin
			tx_state_reg <= ubal_pkg::UBAL_TX_IDLE;
			tx_shift_reg <= 12'hfff;
			tx_left_reg  <= 4'h0;
			tx_phase_reg <= 4'h0;
		end else begin
			unique case (tx_state_reg)
				ubal_pkg::UBAL_TX_IDLE: begin
					if (tx_load) begin
						tx_shift_reg <= {2'b11, tx_field, 1'b0};
						tx_left_reg  <= nbits + (stop2_reg ? 4'h3 : 4'h2);
						tx_phase_reg <= 4'h0;
						tx_state_reg <= ubal_pkg::UBAL_TX_SHIFT;
					end
				end
				ubal_pkg::UBAL_TX_SHIFT: begin
					if (os_tick && tx_phase_reg == tx_lim) begin
						tx_phase_reg <= 4'h0;
						tx_shift_reg <= {1'b1, tx_shift_reg[11:1]};
						tx_left_reg  <= tx_left_reg - 4'h1;
						if (tx_left_reg == 4'h1)
							tx_state_reg <= ubal_pkg::UBAL_TX_IDLE;
					end else if (os_tick) begin
						tx_phase_reg <= tx_phase_reg + 4'h1;
					end
				end
			endcase
		end
	end
	assign SERIAL_TX_PIN = tx_shift_reg[0];

	// Buffer-empty flag: set on load and on low-power entry.
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) tx_buffer_empty_flag_reg <= 1'b1;
		else if (LP_ENTER) tx_buffer_empty_flag_reg <= 1'b1;
		else if (wr_txbuf) tx_buffer_empty_flag_reg <= 1'b0;
		else if (tx_load) tx_buffer_empty_flag_reg <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// Receiver. In loopback the shifter output feeds it directly.
	assign rx_in = loop ? tx_shift_reg[0] : SERIAL_RX_PIN;
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rx_state_reg <= ubal_pkg::UBAL_RX_IDLE;
			rx_phase_reg <= 4'h0;
			rx_cnt_reg   <= 4'h0;
			rx_shift_reg <= 9'h000;
		end else if (LP_ENTER) begin
			rx_state_reg <= ubal_pkg::UBAL_RX_IDLE;
			rx_phase_reg <= 4'h0;
		end else begin
			unique case (rx_state_reg)
				ubal_pkg::UBAL_RX_IDLE: begin
					rx_phase_reg <= 4'h0;
					if (!rx_in) rx_state_reg <= ubal_pkg::UBAL_RX_START;
				end
				ubal_pkg::UBAL_RX_START: begin
					// Recheck at half a bit to reject glitches.
					if (os_tick && rx_phase_reg == (os_lim >> 1)) begin
						rx_phase_reg <= 4'h0;
						rx_cnt_reg   <= 4'h0;
						rx_state_reg <= rx_in ? ubal_pkg::UBAL_RX_IDLE :
							ubal_pkg::UBAL_RX_DATA;
					end else if (os_tick) begin
						rx_phase_reg <= rx_phase_reg + 4'h1;
					end
				end
				ubal_pkg::UBAL_RX_DATA: begin
					if (os_tick && rx_phase_reg == os_lim) begin
						rx_phase_reg <= 4'h0;
						rx_shift_reg <= {rx_in, rx_shift_reg[8:1]};
						rx_cnt_reg   <= rx_cnt_reg + 4'h1;
						if (rx_cnt_reg == nbits - 4'h1)
							rx_state_reg <= ubal_pkg::UBAL_RX_STOP;
					end else if (os_tick) begin
						rx_phase_reg <= rx_phase_reg + 4'h1;
					end
				end
				ubal_pkg::UBAL_RX_STOP: begin
					// Only one stop bit is checked whatever is programmed.
					if (os_tick && rx_phase_reg == os_lim)
						rx_state_reg <= ubal_pkg::UBAL_RX_IDLE;
					else if (os_tick)
						rx_phase_reg <= rx_phase_reg + 4'h1;
				end
			endcase
		end
	end

	// Align the shifted character and pick out its ninth bit.
	assign rx_done = rx_state_reg == ubal_pkg::UBAL_RX_STOP && os_tick &&
		rx_phase_reg == os_lim && !LP_ENTER;
	always_comb begin
		case (nbits)
			4'h9: begin
				rx_data = rx_shift_reg[7:0];
				rx_nin  = rx_shift_reg[8];
			end
			4'h8: begin
				rx_data = rx_shift_reg[8:1];
				rx_nin  = 1'b0;
			end
			default: begin
				rx_data = {1'b0, rx_shift_reg[8:2]};
				rx_nin  = 1'b0;
			end
		endcase
	end
	// Under address watch only characters with the ninth bit set pass.
	assign rx_accept = rx_done && !(address_watch_enable_reg && !rx_nin);

	// Holding buffer is kept across low-power entry.
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) rxbuf_reg <= `UBAL_RST_BYTE;
		else if (rx_accept) rxbuf_reg <= rx_data;
	end

	// Read-only receive flags. A hardware set beats a software clear.
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rx_buffer_full_flag_reg <= 1'b0;
			rx9_reg  <= 1'b0;
			ferr_reg <= 1'b0;
			oerr_reg <= 1'b0;
		end else if (LP_ENTER) begin
			rx_buffer_full_flag_reg <= 1'b0;
			rx9_reg  <= 1'b0;
			ferr_reg <= 1'b0;
			oerr_reg <= 1'b0;
		end else begin
			if (rx_accept) rx_buffer_full_flag_reg <= 1'b1;
			else if (rd_rxbuf) rx_buffer_full_flag_reg <= 1'b0;
			if (rx_accept) rx9_reg <= rx_nin;
			if (rx_accept && !rx_in) ferr_reg <= 1'b1;
			else if (wr_rxcs) ferr_reg <= 1'b0;
			if (rx_accept && rx_buffer_full_flag_reg && !rd_rxbuf) oerr_reg <= 1'b1;
			else if (wr_rxcs) oerr_reg <= 1'b0;
		end
	end

	// Address watch: software sets it, an accepted address clears it.
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) address_watch_enable_reg <= 1'b0;
		else if (rx_accept && address_watch_enable_reg) address_watch_enable_reg <= 1'b0;
		else if (wr_rxcs) address_watch_enable_reg <= PWDATA[`UBAL_RXCS_ADDRESS_WATCH_ENABLE];
	end

	assign RX_IRQ = rx_buffer_full_flag_reg && eri_reg;

	////////////////////////////////////////////////////////////////////////
	// Wake on start bit and crystal settling hold.
	ubal_wake u_wake (
		.clk        (MCLK),
		.rst_n      (RESET_N),
		.lp_enter   (LP_ENTER),
		.rx_pin     (SERIAL_RX_PIN),
		.wake_en3   (WAKE_EN3),
		.wake_edge3 (WAKE_EDGE3),
		.xtal_halt  (XTAL_HALT),
		.wakeup     (WAKEUP),
		.exec_hold  (EXEC_HOLD)
	);

	////////////////////////////////////////////////////////////////////////
	property p_lp_init;
		@(posedge MCLK) disable iff (!RESET_N)
		LP_ENTER |=> tx_buffer_empty_flag_reg && !rx_buffer_full_flag_reg && !ferr_reg && !oerr_reg &&
			tx_shift_reg == 12'hfff && tx_state_reg == ubal_pkg::UBAL_TX_IDLE;
	endproperty
	a_lp_init: assert property (p_lp_init)
		else $error("low-power entry did not reinitialise");

	property p_lp_keep;
		@(posedge MCLK) disable iff (!RESET_N)
		LP_ENTER && !wr_txbuf |=> txbuf_reg == $past(txbuf_reg) &&
			rxbuf_reg == $past(rxbuf_reg) &&
			rx_shift_reg == $past(rx_shift_reg);
	endproperty
	a_lp_keep: assert property (p_lp_keep)
		else $error("low-power entry disturbed a buffer");

	property p_loop;
		@(posedge MCLK) disable iff (!RESET_N)
		cl_reg == 2'b11 |-> rx_in == tx_shift_reg[0] && nbits == 4'h9;
	endproperty
	a_loop: assert property (p_loop)
		else $error("loopback path not connected");

	property p_drop_data;
		@(posedge MCLK) disable iff (!RESET_N)
		rx_done && address_watch_enable_reg && !rx_nin && !LP_ENTER |=>
			address_watch_enable_reg && rxbuf_reg == $past(rxbuf_reg) &&
			rx_buffer_full_flag_reg == ($past(rx_buffer_full_flag_reg) && !$past(rd_rxbuf));
	endproperty
	a_drop_data: assert property (p_drop_data)
		else $error("data character accepted under address watch");

	property p_addr_take;
		@(posedge MCLK) disable iff (!RESET_N)
		rx_done && address_watch_enable_reg && rx_nin && !LP_ENTER |=>
			rx_buffer_full_flag_reg && !address_watch_enable_reg && rx9_reg;
	endproperty
	a_addr_take: assert property (p_addr_take)
		else $error("address character not taken");

	property p_err_clear;
		@(posedge MCLK) disable iff (!RESET_N)
		wr_rxcs && !rx_accept |=> !ferr_reg && !oerr_reg;
	endproperty
	a_err_clear: assert property (p_err_clear)
		else $error("status write left an error flag");

	property p_rd_clear;
		@(posedge MCLK) disable iff (!RESET_N)
		rd_rxbuf && !rx_accept |=> !rx_buffer_full_flag_reg ##1 rx_buffer_full_flag_reg == $past(rx_accept);
	endproperty
	a_rd_clear: assert property (p_rd_clear)
		else $error("buffer read did not clear full flag");
endmodule : ubal_top

// ==== sim/ubal_node.sv ====
// Remote serial node that sends nine-bit frames to the block.
// Assumes the line idles high, as through a pull-up.
`timescale 1ns/1ps
module ubal_node (
	input  wire logic clk,
	output logic      line
);
	initial line = 1'b1;
	////////////////////////////////////////////////////////////////////////
	// One frame: start, nine data bits LSB first, one stop bit.
	// A set ninth bit marks an address character.
	task send(input logic [8:0] d, input int bc);
		for (int i = 0; i < 11; i++) begin
			@(posedge clk);
			line <= (i == 0) ? 1'b0 : (i == 10) ? 1'b1 : d[i-1];
			repeat (bc - 1) @(posedge clk);
		end
	endtask : send
endmodule : ubal_node

// ==== sim/usart_baud_attention_loopback_tb.sv ====
// Self-checking bench for the serial block top.
// Assumes the partner node model drives the receive pin.
`timescale 1ns/1ps
module usart_baud_attention_loopback_tb;
	logic        MCLK, RESET_N, PSEL, PENABLE, PWRITE, LP_ENTER;
	logic        XTAL_HALT, WAKE_EN3, WAKE_EDGE3, SERIAL_RX_PIN;
	logic        PREADY, PSLVERR, SERIAL_TX_PIN, WAKEUP, EXEC_HOLD, RX_IRQ;
	logic [7:0]  PADDR;
	logic [31:0] PWDATA, PRDATA, got, r, e, seed;
	logic [31:0] q[$];
	string       nq[$], s;
	logic        sl;
	int          err_total, check_count, cyc, n, w, h;
	event        rdone;
	logic [7:0]  psr_v[3] = '{8'h18, 8'h10, 8'h18};
	logic [7:0]  div_v[3] = '{8'h01, 8'h00, 8'h01};
	int          exp_v[3] = '{576, 216, 72};
	ubal_top dut_u (.MCLK(MCLK), .RESET_N(RESET_N), .PSEL(PSEL),
		.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
		.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
		.SERIAL_RX_PIN(SERIAL_RX_PIN), .SERIAL_TX_PIN(SERIAL_TX_PIN),
		.LP_ENTER(LP_ENTER), .XTAL_HALT(XTAL_HALT), .WAKE_EN3(WAKE_EN3),
		.WAKE_EDGE3(WAKE_EDGE3), .WAKEUP(WAKEUP), .EXEC_HOLD(EXEC_HOLD),
		.RX_IRQ(RX_IRQ));
	ubal_node node_u (.clk(MCLK), .line(SERIAL_RX_PIN));
	////////////////////////////////////////////////////////////////////////
	// Free-running clock and a hang guard that ends the run.
	always #5 MCLK = ~MCLK;
	always @(posedge MCLK) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			summarize;
		end
	end
	// Takes the oldest note and compares it with the result.
	always @(rdone) begin
		e = q.pop_front();
		s = nq.pop_front();
		check_count++;
		if (got !== e) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", s, e, got);
		end
	end
	////////////////////////////////////////////////////////////////////////
	// The delay keeps two notes in one step from merging.
	task chk(input string t, input logic [31:0] x, input logic [31:0] g);
		q.push_back(x);
		nq.push_back(t);
		got = g;
		->rdone;
		#1;
	endtask : chk
	// APB transfer; request held until pready is sampled high.
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge MCLK);
		PSEL <= 1'b1;
		PWRITE <= wr;
		PADDR <= a;
		PWDATA <= d;
		@(posedge MCLK);
		PENABLE <= 1'b1;
		do @(posedge MCLK); while (PREADY !== 1'b1);
		r = PRDATA;
		sl = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask : apb
	task rd(input string t, input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(t, x, r);
	endtask : rd
	// Counts the clocks of one low stretch on the transmit pin.
	task lowlen(output int k);
		k = 0;
		wait (SERIAL_TX_PIN === 1'b0);
		while (SERIAL_TX_PIN === 1'b0) begin
			@(posedge MCLK);
			#1;
			k++;
		end
	endtask : lowlen
	function logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction : xs
	task summarize;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : summarize
	////////////////////////////////////////////////////////////////////////
	// Main sequence: reset, baud rates, loopback, address watch, sleep.
	initial begin
		{MCLK, RESET_N, PSEL, PENABLE, PWRITE, LP_ENTER} = 6'h0;
		{XTAL_HALT, WAKE_EN3, WAKE_EDGE3} = 3'b111;
		PADDR = 8'h00;
		PWDATA = 32'h0;
		seed = 32'h0de3d43c;
		repeat (20) @(posedge MCLK);
		RESET_N <= 1'b1;
		rd("ctrl", 8'h00, 32'h20);
		rd("psr", 8'h14, 32'h0);
		chk("slverr", 32'h0, sl);
		rd("unmapped", 8'h40, 32'h0);
		chk("slverr", 32'h1, sl);
		for (int i = 0; i < 3; i++) begin
			// Reprogramming mid-frame would stretch the frame, so wait.
			do apb(1'b0, 8'h00, 32'h0); while (r[6] !== 1'b0);
			apb(1'b1, 8'h14, 32'h0);
			apb(1'b1, 8'h18, {31'h0, i == 2});
			apb(1'b1, 8'h10, {24'h0, div_v[i]});
			apb(1'b1, 8'h14, {24'h0, psr_v[i]});
			apb(1'b1, 8'h08, 32'h0);
			lowlen(n);
			chk("low time", exp_v[i], n);
		end
		$display("baud test done");
		apb(1'b1, 8'h14, 32'h0);
		apb(1'b1, 8'h18, 32'h2);
		apb(1'b1, 8'h10, 32'h0);
		apb(1'b1, 8'h14, 32'h08);
		repeat (2) begin
			seed = xs(seed);
			apb(1'b1, 8'h00, {29'h0, seed[8], 2'b11});
			apb(1'b1, 8'h08, {24'h0, seed[7:0]});
			do apb(1'b0, 8'h04, 32'h0); while (r[4] !== 1'b1);
			rd("rxcs", 8'h04, {27'h1, 2'b0, seed[8], 1'b0});
			chk("irq", 32'h1, RX_IRQ);
			rd("rxbuf", 8'h0c, {24'h0, seed[7:0]});
			rd("rxcs", 8'h04, {30'h0, seed[8], 1'b0});
		end
		$display("loopback test done");
		apb(1'b1, 8'h00, 32'h2);
		// A divisor of two divides by three: forty-eight clocks per bit here.
		apb(1'b1, 8'h14, 32'h0);
		apb(1'b1, 8'h10, 32'h2);
		apb(1'b1, 8'h14, 32'h08);
		apb(1'b1, 8'h04, 32'h1);
		node_u.send(9'h055, 48);
		rd("watch", 8'h04, {30'h0, seed[8], 1'b1});
		node_u.send(9'h1a3, 48);
		rd("watch", 8'h04, 32'h12);
		chk("irq", 32'h1, RX_IRQ);
		$display("address watch test done");
		apb(1'b1, 8'h04, 32'h1);
		// Start a frame so that low-power entry finds the pin low.
		apb(1'b1, 8'h08, 32'h0);
		@(posedge MCLK) LP_ENTER <= 1'b1;
		@(posedge MCLK) LP_ENTER <= 1'b0;
		rd("ctrl", 8'h00, 32'h22);
		rd("rxcs", 8'h04, 32'h01);
		chk("tx pin", 32'h1, SERIAL_TX_PIN);
		rd("rxbuf", 8'h0c, 32'ha3);
		fork
			node_u.send(9'h0ff, 48);
			repeat (400) begin
				@(posedge MCLK);
				#1;
				w += WAKEUP;
				h += EXEC_HOLD;
			end
		join
		chk("wake", 32'h1, w);
		chk("hold", 32'd256, h);
		$display("sleep test done");
		summarize;
	end
endmodule : usart_baud_attention_loopback_tb
